// *** common/clkdiv_defs.svh ***
/*
 * Constants for the double-speed clock divider: register map, field
 * positions, reset value and cycle counts.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef CLKDIV_DEFS_SVH
`define CLKDIV_DEFS_SVH
// ****************************************************
// Register map
// ****************************************************
`define SPEED_CTRL_INDEX 32'h0000008f
`define SPEED_CTRL_ADDR (`SPEED_CTRL_INDEX * 32'h4)
`define SPEED_CTRL_RESET 7'h00
`define SPEED_CTRL_WIDTH 7
// ****************************************************
// Field positions
// ****************************************************
`define CORE_SEL_BIT 0
`define PERIPH_SEL_LSB 1
`define PERIPH_SEL_MSB 6
`define SERIAL_INDEX 3
// ****************************************************
// Cycle counts and bus codes
// ****************************************************
`define STD_PERIOD 4'hc
`define FAST_PERIOD 4'h6
`define CORE_PHASES 4'h6
`define HTRANS_NONSEQ_BIT 1
`define SERIAL_MODE_ZERO 2'h0
`define SERIAL_MODE_TWO 2'h2
`endif

// *** common/clkdiv_pkg.sv ***
/*
 * Types shared by the clock divider modules.
 * Assumes the constants header is compiled with it.
 */
package clkdiv_pkg;
  // Peripheral order within the select field, bit 1 upward
  typedef enum logic [2:0] {
    TIMER_ZERO, TIMER_ONE, TIMER_TWO, SERIAL_PORT, COUNTER_ARRAY, WATCHDOG
  } periph_type;
  // One select per peripheral
  typedef logic [5:0] periph_sel_type;
  // Period count in crystal periods
  typedef logic [3:0] period_type;
endpackage

// *** common/speed_reg_if.sv ***
/*
 * Register access carrier between the bus slave and the divider core.
 * Assumes one clock; the write strobe is a one-cycle pulse.
 */
`timescale 1ns/100ps
interface speed_reg_if;
  logic wrEn; // One-cycle write strobe
  logic [7:0] wrData; // Byte written by software
  logic [7:0] rdData; // Current register image
  // Bus side drives writes, reads the image
  modport slave (output wrEn, output wrData, input rdData);
  // Register owner takes writes, shows the image
  modport owner (input wrEn, input wrData, output rdData);
endinterface // speed_reg_if

// *** src/period_strobe.sv ***
/*
 * Counts enable ticks and emits a one-cycle strobe every limit ticks.
 * Assumes limit is at least two and only changes between periods or at
 * a wrap; a shorter limit arriving mid-count wraps at once.
 */
`timescale 1ns/100ps
module period_strobe
  import clkdiv_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire period_type limit,
  output logic strobe
);
  // ****************************************************
  // Tick counter
  // ****************************************************
  period_type count; // Ticks seen in this period
  wire logic atEnd; // Last tick of the period
  wire period_type next_count;
  assign atEnd = count >= period_type'(limit - 4'h1);
  assign next_count = atEnd ? 4'h0 : period_type'(count + 4'h1);
  // Advance on tick, strobe on the wrapping tick
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
      strobe <= 1'h0;
    end else begin
      strobe <= tick && atEnd;
      if (tick) begin
        count <= next_count;
      end
    end
  end
endmodule // period_strobe

// *** src/ahb_lite_slave.sv ***
/*
 * AHB-Lite slave for the one speed control register.
 * Assumes single word transfers; zero wait states, always OKAY.
 */
`timescale 1ns/100ps
`include "clkdiv_defs.svh"
module ahb_lite_slave
  import clkdiv_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  speed_reg_if.slave regPort
);
  // ****************************************************
  // Address phase decode
  // ****************************************************
  wire logic addrTaken; // Valid transfer accepted this edge
  wire logic hit; // Address names the register
  wire logic [7:0] fwdData; // Image seen by a read
  logic pendWrite; // Write data phase in progress
  assign addrTaken = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
  assign hit = haddr == `SPEED_CTRL_ADDR;
  // A write in its data phase is forwarded so a read right behind it
  // sees the new value, not the stale one
  assign fwdData = pendWrite ? {1'h0, hwdata[6:0]} : regPort.rdData;
  // Whole byte only: the low byte of the word lands at once
  assign regPort.wrEn = pendWrite;
  assign regPort.wrData = hwdata[7:0];
  // ****************************************************
  // Data phase
  // ****************************************************
  // Read data captured at the address edge, write marked for next cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pendWrite <= 1'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      pendWrite <= addrTaken && hwrite && hit;
      if (addrTaken && !hwrite) begin
        hrdata <= hit ? {24'h0, fwdData} : 32'h0;
      end
    end
  end
  // ****************************************************
  // Checks
  // ****************************************************
  AST_WRITE_TAKES: assert property (@(posedge mclk) disable iff (!rst_n)
    addrTaken && hwrite && hit |=> regPort.wrEn)
    else $error("register write not passed on");
  AST_READ_HIGH_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    hrdata[31:7] == 25'h0)
    else $error("reserved read bits not zero");
  COV_BUS_WRITE: cover property (@(posedge mclk) disable iff (!rst_n)
    addrTaken && hwrite && hit);
endmodule // ahb_lite_slave

// *** src/double_speed_clock_divider.sv ***
/*
 * Double-speed clock divider: halves the crystal clock in standard
 * mode, bypasses the halving in double-speed mode, and gives the core
 * and six peripherals their cycle strobes.
 * Assumes mclk is the crystal input, the register is reached over
 * AHB-Lite, and serialMode comes from logic on the same clock.
 */
`timescale 1ns/100ps
`include "clkdiv_defs.svh"
module double_speed_clock_divider
  import clkdiv_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] serialMode,
  output logic halfClock,
  output logic doubleSpeedActive,
  output logic phaseClkEn,
  output logic coreCycle,
  output periph_sel_type periphCycle
);
  // ****************************************************
  // Helper functions
  // ****************************************************
  // Period of a peripheral in crystal periods
  function automatic period_type periodFor(input logic fast);
    periodFor = fast ? `FAST_PERIOD : `STD_PERIOD;
  endfunction
  // Serial modes whose clock the select may speed up
  function automatic logic serialSpeedable(input logic [1:0] mode);
    serialSpeedable = (mode == `SERIAL_MODE_ZERO) ||
                      (mode == `SERIAL_MODE_TWO);
  endfunction

  // ****************************************************
  // Register access
  // ****************************************************
  speed_reg_if regBus (); // Slave to register carrier
  ahb_lite_slave busSlave (
    .mclk(mclk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .regPort(regBus.slave)
  );

  // Software image of the control register, bit 7 not stored
  logic [`SPEED_CTRL_WIDTH-1:0] speedControl;
  wire logic doubleSpeedCoreSelect; // Core select as written
  wire periph_sel_type periphSelect; // Peripheral selects as written
  assign doubleSpeedCoreSelect = speedControl[`CORE_SEL_BIT];
  assign periphSelect =
    speedControl[`PERIPH_SEL_MSB:`PERIPH_SEL_LSB];
  // Reserved bit reads as zero
  assign regBus.rdData = {1'h0, speedControl};

  // Bit 7 is dropped on write, so software always reads it back as zero
  // Register write; reset brings standard speed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speedControl <= `SPEED_CTRL_RESET;
    end else if (regBus.wrEn) begin
      speedControl <= regBus.wrData[`SPEED_CTRL_WIDTH-1:0];
    end
  end

  // ****************************************************
  // Halving stage
  // ****************************************************
  // The halved clock is a toggle; its rising edge is the cycle in
  // which it is low and about to go high
  wire logic halfRise; // Halved clock rises at this edge
  assign halfRise = !halfClock;

  // Runs in both modes, so the halved-clock rise that times every
  // switch is always there to take a new select
  // Divide by two of the crystal input
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halfClock <= 1'h0;
    end else begin
      halfClock <= !halfClock;
    end
  end

  // ****************************************************
  // Glitch-free mode switch
  // ****************************************************
  // Selects are taken only at a halved-clock rise, so a switch never
  // cuts a half period short; a write waits at most two crystal periods
  periph_sel_type activeSel; // Peripheral selects in force
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      doubleSpeedActive <= 1'h0;
      activeSel <= 6'h00;
    end else if (halfRise) begin
      doubleSpeedActive <= doubleSpeedCoreSelect;
      activeSel <= periphSelect;
    end
  end

  // ****************************************************
  // Phase generator clock enable
  // ****************************************************
  // Standard mode feeds the phase generator from the halved clock,
  // double-speed mode straight from the crystal
  wire logic next_phaseClkEn;
  assign next_phaseClkEn = doubleSpeedActive ? 1'h1 : halfRise;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phaseClkEn <= 1'h0;
    end else begin
      phaseClkEn <= next_phaseClkEn;
    end
  end

  // ****************************************************
  // Core machine cycle
  // ****************************************************
  // Six phase enables per machine cycle: twelve crystal periods when
  // halved, six when bypassed
  // The count free-runs across a switch: a user must allow one machine
  // cycle of mixed length right after the mode changes
  period_strobe coreCounter (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(phaseClkEn),
    .limit(`CORE_PHASES),
    .strobe(coreCycle)
  );

  // ****************************************************
  // Peripheral cycle strobes
  // ****************************************************
  // A peripheral runs fast only in double-speed mode with its select
  // clear; the serial select counts only in modes 0 and 2
  // A shorter limit arriving mid-count wraps at once, never runs long
  periph_sel_type periphFast; // Peripheral runs at six periods
  wire logic serialOk; // Serial mode allows the fast clock
  assign serialOk = serialSpeedable(serialMode);
  always_comb begin
    periphFast = 6'h00;
    for (int i = 0; i < 6; i++) begin
      periphFast[i] = doubleSpeedActive && !activeSel[i];
    end
    periphFast[`SERIAL_INDEX] = periphFast[`SERIAL_INDEX] && serialOk;
  end

  // One counter per peripheral on the crystal clock
  // Separate counters cost area, but one fast select never disturbs
  // the phase of another peripheral
  for (genvar g = 0; g < 6; g++) begin : gPeriph
    period_strobe periphCounter (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(1'h1),
      .limit(periodFor(periphFast[g])),
      .strobe(periphCycle[g])
    );
  end

  // ****************************************************
  // Check helpers
  // ****************************************************
  // Crystal periods since the last core strobe, and whether the mode
  // held steady across them
  // A switch landing on the very edge of a core strobe only touches the
  // next period, so the flag restarts from the pending difference and
  // not from zero; otherwise a mixed period would be judged as clean
  logic [4:0] coreGap;
  logic modeMoved;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coreGap <= 5'h00;
      modeMoved <= 1'h1;
    end else if (coreCycle) begin
      coreGap <= 5'h00;
      modeMoved <= doubleSpeedActive != doubleSpeedCoreSelect;
    end else begin
      coreGap <= 5'(coreGap + 5'h01);
      modeMoved <= modeMoved || (doubleSpeedActive != doubleSpeedCoreSelect);
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  // Every check runs on the crystal clock and rests while reset is low;
  // the halved clock is a level here, never a clock of its own
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_STD_HALVES: assert property (
    !doubleSpeedActive && $past(!doubleSpeedActive) && phaseClkEn
    |=> !phaseClkEn)
    else $error("standard mode phase enable not halved");

  AST_DOUBLE_BYPASS: assert property (
    doubleSpeedActive && $past(doubleSpeedActive) |-> phaseClkEn)
    else $error("double mode phase enable missing");

  // Periods in which the mode moved are skipped: the first period after
  // a switch may mix both lengths
  AST_CORE_SIX: assert property (
    coreCycle && !modeMoved && doubleSpeedActive
    && $past(doubleSpeedActive, 2) |-> coreGap == 5'h05)
    else $error("double mode core cycle not six periods");

  AST_CORE_TWELVE: assert property (
    coreCycle && !modeMoved && !doubleSpeedActive
    && $past(!doubleSpeedActive, 2) |-> coreGap == 5'h0b)
    else $error("standard core cycle not twelve periods");

  AST_SWITCH_ON_HALF: assert property (
    $changed(doubleSpeedActive) |-> $past(halfRise))
    else $error("core mode changed off the halved edge");

  AST_SEL_ON_HALF: assert property (
    $changed(activeSel) |-> $past(halfRise))
    else $error("peripheral select changed off the halved edge");

  AST_RESET_STD: assert property (
    $past(!rst_n) |-> speedControl == 7'h00 && !doubleSpeedActive)
    else $error("reset did not give standard mode");

  AST_PERIPH_IGNORED: assert property (
    !doubleSpeedActive |-> periphFast == 6'h00)
    else $error("peripheral fast outside double mode");

  AST_PERIPH_POLARITY: assert property (
    doubleSpeedActive && !activeSel[0] |-> periphFast[0])
    else $error("cleared select did not give six periods");

  AST_PERIPH_GAP: assert property (
    periphCycle[1] && periphFast[1] ##1 periphFast[1] [*5]
    |=> periphCycle[1])
    else $error("fast peripheral strobe not six periods");

  AST_SERIAL_MODES: assert property (
    !serialSpeedable(serialMode) |-> !periphFast[`SERIAL_INDEX])
    else $error("serial fast outside modes 0 and 2");

  AST_LAYOUT: assert property (
    regBus.wrEn |=> doubleSpeedCoreSelect == $past(regBus.wrData[0])
    && periphSelect == $past(regBus.wrData[6:1]))
    else $error("register fields misplaced");

  // Halved clock toggles on every crystal edge once out of reset
  AST_HALF_TOGGLE: assert property (
    $past(rst_n) |-> halfClock != $past(halfClock))
    else $error("halved clock did not toggle");

  // Selects land exactly as they stood at the halved-clock rise
  AST_ACTIVE_FOLLOWS: assert property (
    halfRise |=> doubleSpeedActive == $past(doubleSpeedCoreSelect))
    else $error("core select not taken at the halved edge");

  AST_SEL_FOLLOWS: assert property (
    halfRise |=> activeSel == $past(periphSelect))
    else $error("peripheral selects not taken at the halved edge");

  AST_CORE_PULSE: assert property (
    coreCycle |=> !coreCycle)
    else $error("core strobe wider than one cycle");

  AST_PERIPH_TWELVE: assert property (
    periphCycle[2] && !periphFast[2] ##1 !periphFast[2] [*8]
    ##1 !periphFast[2] [*3] |=> periphCycle[2])
    else $error("slow peripheral strobe not twelve periods");

  AST_SERIAL_FAST: assert property (
    doubleSpeedActive && !activeSel[`SERIAL_INDEX]
    && serialSpeedable(serialMode) |-> periphFast[`SERIAL_INDEX])
    else $error("serial not fast in its fast modes");

  // The bus never stalls and never reports an error
  AST_BUS_OKAY: assert property (
    hreadyout && !hresp)
    else $error("register bus not ready and okay");

  COV_ENTER_DOUBLE: cover property ($rose(doubleSpeedActive));
  COV_LEAVE_DOUBLE: cover property ($fell(doubleSpeedActive));
  COV_FAST_PERIPH: cover property (periphCycle[5] && periphFast[5]);
  COV_SERIAL_SLOW: cover property (
    doubleSpeedActive && !activeSel[3] && !serialOk);
endmodule // double_speed_clock_divider

// *** verif/cycle_consumer.sv ***
/*
 * Far-side model: the core phase generator and peripheral clock users.
 * It measures the spacing, in crystal cycles, of each strobe it gets.
 * Assumes one clock, strobes one cycle wide, reset asynchronous low.
 */
`timescale 1ns/100ps
module cycle_consumer
  import clkdiv_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic phaseClkEn,
  input wire logic coreCycle,
  input wire periph_sel_type periphCycle,
  output logic [7:0] phaseGap,
  output logic [7:0] coreGap,
  output logic [5:0][7:0] periphGap
);
  // ****************************************************
  // Spacing counters
  // ****************************************************
  logic [7:0] phaseCnt; // Cycles since last phase enable
  logic [7:0] coreCnt; // Cycles since last machine cycle
  logic [5:0][7:0] periphCnt; // Cycles since each peripheral strobe

  // Each counter restarts at one on its strobe and saturates otherwise;
  // saturation keeps a stuck strobe from wrapping into a plausible gap
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phaseCnt <= 8'h01;
      coreCnt <= 8'h01;
      periphCnt <= {6{8'h01}};
      phaseGap <= 8'h00;
      coreGap <= 8'h00;
      periphGap <= '0;
    end else begin
      phaseCnt <= phaseClkEn ? 8'h01 : phaseCnt + {7'h00, phaseCnt != 8'hff};
      coreCnt <= coreCycle ? 8'h01 : coreCnt + {7'h00, coreCnt != 8'hff};
      if (phaseClkEn) phaseGap <= phaseCnt;
      if (coreCycle) coreGap <= coreCnt;
      for (int i = 0; i < 6; i++) begin
        // Each peripheral counted on its own
        if (periphCycle[i]) begin
          periphGap[i] <= periphCnt[i];
          periphCnt[i] <= 8'h01;
        end else if (periphCnt[i] != 8'hff) begin
          periphCnt[i] <= periphCnt[i] + 8'h01;
        end
      end
    end
  end
endmodule // cycle_consumer

// *** verif/tb_double_speed_clock_divider.sv ***
/*
 * Self-checking bench: register access over AHB-Lite, mode switching
 * and strobe spacing compared with a behavioural model.
 * Assumes zero-wait slave with hready looped back from hreadyout.
 */
`timescale 1ns/100ps
`include "clkdiv_defs.svh"
module tb_double_speed_clock_divider
  import clkdiv_pkg::*;
;
  // ****************************************************
  // Signals
  // ****************************************************
  logic mclk, rst_n, hsel, hwrite; // Clock, reset and bus control
  logic [31:0] haddr, hwdata, hrdata; // Bus address and data
  logic [1:0] htrans, serialMode; // Transfer type, serial mode
  logic [2:0] hsize; // Transfer size
  logic hreadyout, hresp, halfClock, doubleSpeedActive; // Status
  logic phaseClkEn, coreCycle; // Core enables
  periph_sel_type periphCycle; // Peripheral strobes
  logic [7:0] phaseGap, coreGap; // Measured spacings
  logic [5:0][7:0] periphGap; // Measured peripheral spacings
  int error_cnt = 0, check_count = 0, cycles = 0; // Bookkeeping
  int seed = 50; // Fixed random seed
  logic [31:0] modelReg, rd, v; // Model register image, scratch
  int expQ[$]; // Expected peripheral spacings
  logic dsaSeen = 1'b0, halfSeen = 1'b0; // Last values at falling edge
  logic rstSeen = 1'b0; // Reset level at the last falling edge

  // 50 MHz crystal
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  double_speed_clock_divider u_double_speed_clock_divider (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .serialMode(serialMode), .halfClock(halfClock),
    .doubleSpeedActive(doubleSpeedActive), .phaseClkEn(phaseClkEn),
    .coreCycle(coreCycle), .periphCycle(periphCycle));

  cycle_consumer u_cycle_consumer (
    .mclk(mclk), .rst_n(rst_n), .phaseClkEn(phaseClkEn),
    .coreCycle(coreCycle), .periphCycle(periphCycle),
    .phaseGap(phaseGap), .coreGap(coreGap), .periphGap(periphGap));

  // ****************************************************
  // Checking and closing
  // ****************************************************
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report;
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  // A mode change must land on an edge where the halved clock was low
  always @(negedge mclk) begin
    if (rst_n && dsaSeen !== doubleSpeedActive) begin
      chk("switchHalf", 32'h0, 32'(halfSeen));
    end
    // Halved clock toggles every crystal cycle once out of reset
    if (rst_n && rstSeen) begin
      chk("halfToggle", 32'(!halfSeen), 32'(halfClock));
    end
    dsaSeen = doubleSpeedActive;
    halfSeen = halfClock;
    rstSeen = rst_n;
  end

  // ****************************************************
  // Bus master and model comparison
  // ****************************************************
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Let spacings settle, then compare everything with the model
  task automatic settle_check;
    logic x2;
    logic fast;
    x2 = modelReg[0];
    repeat (40) @(posedge mclk);
    chk("active", 32'(x2), 32'(doubleSpeedActive));
    chk("phaseGap", x2 ? 32'h1 : 32'h2, 32'(phaseGap));
    chk("coreGap", x2 ? 32'h6 : 32'hc, 32'(coreGap));
    for (int i = 0; i < 6; i++) begin
      // Serial fast clock only in serial modes 0 and 2
      fast = x2 && !modelReg[i + 1] &&
             (i != 3 || serialMode == 2'h0 || serialMode == 2'h2);
      expQ.push_back(fast ? 6 : 12);
    end
    for (int i = 0; i < 6; i++) begin
      chk("periphGap", 32'(expQ.pop_front()), 32'(periphGap[i]));
    end
    chk("hresp", 32'h0, 32'(hresp));
    chk("hreadyout", 32'h1, 32'(hreadyout));
    bus(1'b0, `SPEED_CTRL_ADDR, 32'h0, rd);
    chk("readback", modelReg, rd);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    serialMode = 2'h0;
    modelReg = 32'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    settle_check();
    // Random images; core select and serial mode walk all cases
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      v[0] = i[0];
      v[4] = i[2]; // Serial select clear in serial modes 0 and 1
      bus(1'b1, `SPEED_CTRL_ADDR, v, rd);
      serialMode <= i[2:1];
      modelReg = v & 32'h7f; // Reserved top bit reads zero
      settle_check();
    end
    // Unmapped place: write ignored, read zero
    bus(1'b1, 32'h0000008c, 32'hffffffff, rd);
    bus(1'b0, 32'h0000008c, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    settle_check();
    // Second reset in mid-run returns standard speed
    bus(1'b1, `SPEED_CTRL_ADDR, 32'h0000007f, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    modelReg = 32'h0;
    @(posedge mclk);
    settle_check();
    final_report();
  end
endmodule // tb_double_speed_clock_divider
